/* common/pes_pkg.sv */
// shared constants, types and helpers of the pattern editor and segment sync block
package pes_pkg;

   // timing
   localparam int unsigned CLK_HZ           = 40_000_000;
   localparam int unsigned SEC_TIME_MS      = 1000;
   localparam int unsigned SEC_CYCLES_DEF   = CLK_HZ / 1000 * SEC_TIME_MS;
   localparam int unsigned BLANK_TIME_MS    = 1000;
   localparam int unsigned BLANK_CYCLES_DEF = CLK_HZ / 1000 * BLANK_TIME_MS;

   // limits, standard and extended
   localparam logic [2:0] PAT_MAX_STD = 3'h2;
   localparam logic [2:0] PAT_MAX_EXT = 3'h4;
   localparam logic [5:0] SEG_MAX_STD = 6'h14;
   localparam logic [5:0] SEG_MAX_EXT = 6'h28;

   // register offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMD     = 8'h04;
   localparam logic [7:0] OFS_RESULT  = 8'h08;
   localparam logic [7:0] OFS_COUNT   = 8'h0C;
   localparam logic [7:0] OFS_RUN     = 8'h10;
   localparam logic [7:0] OFS_SEGTIME = 8'h14;
   localparam logic [7:0] OFS_STATUS  = 8'h18;

   // field positions
   localparam int unsigned CTRL_EXT_BIT    = 0;
   localparam int unsigned CTRL_WSW_BIT    = 1;
   localparam int unsigned CTRL_WSEL_BIT   = 2;
   localparam int unsigned CTRL_AL3_BIT    = 3;
   localparam int unsigned CTRL_JC_LSB     = 4;
   localparam int unsigned CMD_OP_LSB      = 0;
   localparam int unsigned CMD_LINK_BIT    = 3;
   localparam int unsigned CMD_PA_LSB      = 8;
   localparam int unsigned CMD_PB_LSB      = 12;
   localparam int unsigned CMD_SEG_LSB     = 16;
   localparam int unsigned RES_COMM_LSB    = 0;
   localparam int unsigned RES_PANEL_LSB   = 8;
   localparam int unsigned RES_REFUSED_BIT = 16;
   localparam int unsigned RES_LINK_BIT    = 17;
   localparam int unsigned RES_BUSY_BIT    = 18;
   localparam int unsigned RES_FREE_LSB    = 24;
   localparam int unsigned RUN_EXEC_BIT    = 0;
   localparam int unsigned ST_FLAG_BIT     = 0;
   localparam int unsigned ST_WAIT_BIT     = 1;
   localparam int unsigned ST_BLANK_BIT    = 2;
   localparam int unsigned ST_EXEC_BIT     = 3;
   localparam int unsigned ST_SEG_LSB      = 8;
   localparam int unsigned ST_REMAIN_LSB   = 16;

   // reset values
   localparam logic [5:0]  CTRL_RST    = 6'h0E;
   localparam logic [15:0] SEGTIME_RST = 16'h0005;

   // communication result codes
   localparam logic [7:0] RC_OK          = 8'h00;
   localparam logic [7:0] RC_RUNNING     = 8'h01;
   localparam logic [7:0] RC_PAT_RANGE   = 8'h02;
   localparam logic [7:0] RC_SEG_RANGE   = 8'h03;
   localparam logic [7:0] RC_SEG_TOTAL   = 8'h16;
   localparam logic [7:0] RC_COPY        = 8'h1F;
   localparam logic [7:0] RC_CLR_MISSING = 8'h29;

   // panel error codes, number part only
   localparam logic [7:0] PE_NONE                         = 8'h00;
   localparam logic [7:0] EDIT_DURING_RUN_ERROR           = 8'h01;
   localparam logic [7:0] SEGMENT_TOTAL_OVERFLOW_ERROR    = 8'h16;
   localparam logic [7:0] SEGMENT_INSERT_OVERFLOW_ERROR   = 8'h17;
   localparam logic [7:0] COPY_SOURCE_EMPTY_ERROR         = 8'h20;
   localparam logic [7:0] COPY_DEST_OCCUPIED_ERROR        = 8'h21;
   localparam logic [7:0] CLEAR_MISSING_PATTERN_ERROR     = 8'h29;

   typedef enum logic [2:0] {
      OP_NONE    = 3'h0,
      OP_CLR_PAT = 3'h1,
      OP_CLR_ALL = 3'h2,
      OP_COPY    = 3'h3,
      OP_INS_SEG = 3'h4,
      OP_DEL_SEG = 3'h5,
      OP_WR_SEG  = 3'h6
   } pes_op_e;

   typedef enum logic [1:0] {
      JC_CONTINUE_JUNCTION = 2'h0,
      JC_WAIT_AT_BOUNDARY  = 2'h1,
      JC_HOLD              = 2'h2
   } pes_jc_e;

   typedef logic [3:0][5:0] pes_cnts_t;

   typedef struct packed {
      pes_op_e    op;
      logic       link;
      logic [2:0] pa;
      logic [2:0] pb;
      logic [5:0] seg;
   } pes_req_s;

   typedef struct packed {
      logic       refused;
      logic [7:0] comm;
      logic [7:0] panel;
   } pes_res_s;

   function automatic logic [2:0] pat_max(input logic ext);
      return ext ? PAT_MAX_EXT : PAT_MAX_STD;
   endfunction : pat_max

   function automatic logic [5:0] seg_max(input logic ext);
      return ext ? SEG_MAX_EXT : SEG_MAX_STD;
   endfunction : seg_max

   function automatic logic [1:0] pat_idx(input logic [2:0] p);
      logic [2:0] d;
      d = p - 3'h1;
      return d[1:0];
   endfunction : pat_idx

   function automatic logic [7:0] seg_total(input pes_cnts_t c);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
         s = s + {2'h0, c[i]};
      end
      return s;
   endfunction : seg_total

endpackage : pes_pkg

/* rtl/pes_edit_check.sv */
// verdict on one pattern edit or clear request
`timescale 1ns/1ps
module pes_edit_check
   import pes_pkg::*;
(
   // request and store state
   input  pes_req_s  req,
   input  logic      running,
   input  logic      ext_opt,
   input  pes_cnts_t cnts,
   // verdict
   output pes_res_s  res
);

   always_comb
   begin
      logic [2:0] maxp;
      logic [5:0] maxs;
      logic [7:0] total;
      logic [5:0] ca;
      logic [5:0] cb;
      maxp  = pat_max(ext_opt);
      maxs  = seg_max(ext_opt);
      total = seg_total(cnts);
      ca    = cnts[pat_idx(req.pa)];
      cb    = cnts[pat_idx(req.pb)];
      res   = '{refused: 1'b0, comm: RC_OK, panel: PE_NONE};
      if (running)
         res = '{refused: 1'b1, comm: RC_RUNNING, panel: EDIT_DURING_RUN_ERROR};
      else if (req.op != OP_CLR_ALL && (req.pa == 3'h0 || req.pa > maxp ||
               (req.op == OP_COPY && (req.pb == 3'h0 || req.pb > maxp))))
         res = '{refused: 1'b1, comm: RC_PAT_RANGE, panel: PE_NONE};
      else if ((req.op == OP_INS_SEG || req.op == OP_DEL_SEG || req.op == OP_WR_SEG) &&
               (req.seg == 6'h00 || req.seg > maxs))
         res = '{refused: 1'b1, comm: RC_SEG_RANGE, panel: PE_NONE};
      else
      begin
         unique case (req.op)
            OP_CLR_PAT:
               if (ca == 6'h00)
                  res = '{refused: 1'b1, comm: RC_CLR_MISSING, panel: CLEAR_MISSING_PATTERN_ERROR};
            OP_COPY:
               if (cb == 6'h00)
                  res = '{refused: 1'b1, comm: RC_COPY, panel: COPY_SOURCE_EMPTY_ERROR};
               else if (ca != 6'h00)
                  res = '{refused: 1'b1, comm: RC_COPY, panel: COPY_DEST_OCCUPIED_ERROR};
               else if (total + {2'h0, cb} > {2'h0, maxs})
                  res = '{refused: 1'b1, comm: RC_SEG_TOTAL, panel: SEGMENT_TOTAL_OVERFLOW_ERROR};
            OP_INS_SEG:
               if (ca >= maxs)
                  res = '{refused: 1'b1, comm: RC_SEG_TOTAL, panel: SEGMENT_INSERT_OVERFLOW_ERROR};
               else if (total >= {2'h0, maxs})
                  res = '{refused: 1'b1, comm: RC_SEG_TOTAL, panel: SEGMENT_TOTAL_OVERFLOW_ERROR};
               else if (req.seg > ca)
                  res = '{refused: 1'b1, comm: RC_SEG_RANGE, panel: PE_NONE};
            OP_DEL_SEG:
               if (req.seg > ca)
                  res = '{refused: 1'b1, comm: RC_SEG_RANGE, panel: PE_NONE};
            OP_WR_SEG:
               if (req.seg > ca + 6'h01)
                  res = '{refused: 1'b1, comm: RC_SEG_RANGE, panel: PE_NONE};
               else if (req.seg == ca + 6'h01 && total >= {2'h0, maxs})
                  res = '{refused: 1'b1, comm: RC_SEG_TOTAL, panel: SEGMENT_TOTAL_OVERFLOW_ERROR};
            default:
               res = '{refused: 1'b0, comm: RC_OK, panel: PE_NONE};
         endcase
      end
   end

endmodule : pes_edit_check

/* rtl/pes_sync_flag.sv */
// transition-control flag with one-second blanking after a segment change
`timescale 1ns/1ps
module pes_sync_flag
   import pes_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = BLANK_CYCLES_DEF
)
(
   // clock and reset
   input  logic clk,
   input  logic rst_n,
   // sequencer state
   input  logic executing,
   input  logic wait_sw,
   input  logic al3_sel,
   input  logic own_wait,
   input  logic remain_nz,
   input  logic seg_adv,
   // flag
   output logic flag_r,
   output logic blank_r
);

   logic [25:0] blank_cnt_r;
   logic        blank_now;

   assign blank_now = seg_adv | (blank_cnt_r != 26'h0000000);

   // one second off after a transition
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         blank_cnt_r <= 26'h0000000;
      else if (seg_adv)
         blank_cnt_r <= 26'(BLANK_CYCLES - 1);
      else if (blank_cnt_r != 26'h0000000)
         blank_cnt_r <= blank_cnt_r - 26'h0000001;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         blank_r <= 1'b0;
      else
         blank_r <= blank_now;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag_r <= 1'b0;
      else
         flag_r <= al3_sel & executing & wait_sw & ~blank_now & (own_wait | remain_nz);
   end

endmodule : pes_sync_flag

/* rtl/pes_top.sv */
// pattern store editor and segment transition sync, APB slave
`timescale 1ns/1ps
module pes_top
   import pes_pkg::*;
#(
   parameter int unsigned SEC_CYCLES   = SEC_CYCLES_DEF,
   parameter int unsigned BLANK_CYCLES = BLANK_CYCLES_DEF
)
(
   // clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // apb slave
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [7:0]  paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // contacts
   input  logic        wait_in,
   input  logic        out_of_zone_in,
   output logic        alarm3_out,
   output logic        seg_advance_out
);

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_TIMING   = 2'b01,
      ST_BOUNDARY = 2'b11,
      ST_HELD     = 2'b10
   } pes_state_e;

   logic [5:0]  ctrl_r;
   logic        exec_r;
   logic [15:0] segtime_r;
   pes_req_s    req_r;
   logic        go_r;
   pes_res_s    res_r;
   logic        res_link_r;
   pes_cnts_t   cnts_r;
   pes_res_s    verdict;
   pes_state_e  state_r;
   pes_state_e  state_nxt;
   logic [15:0] remain_r;
   logic [5:0]  seg_r;
   logic [25:0] sec_cnt_r;
   logic        sec_tick;
   logic        seg_adv_r;
   logic        own_wait;
   logic        wait_eff;
   logic        advance;
   logic        running;
   logic        flag;
   logic        blank;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic        wr_done;
   logic        mapped;
   logic [31:0] rd_word;
   pes_jc_e     jc;

   assign jc      = pes_jc_e'(ctrl_r[CTRL_JC_LSB +: 2]);
   assign running = (state_r != ST_IDLE);
   assign wr_done = psel & penable & pready_r & pwrite;
   assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_RESULT) ||
                    (paddr == OFS_COUNT) || (paddr == OFS_RUN) || (paddr == OFS_SEGTIME) ||
                    (paddr == OFS_STATUS);

   // apb answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & ~mapped;
      end
   end

   always_comb
   begin
      rd_word = 32'h00000000;
      unique case (paddr)
         OFS_CTRL:
            rd_word[5:0] = ctrl_r;
         OFS_CMD:
         begin
            rd_word[CMD_OP_LSB +: 3]  = req_r.op;
            rd_word[CMD_LINK_BIT]     = req_r.link;
            rd_word[CMD_PA_LSB +: 3]  = req_r.pa;
            rd_word[CMD_PB_LSB +: 3]  = req_r.pb;
            rd_word[CMD_SEG_LSB +: 6] = req_r.seg;
         end
         OFS_RESULT:
         begin
            rd_word[RES_COMM_LSB +: 8]  = res_r.comm;
            rd_word[RES_PANEL_LSB +: 8] = res_r.panel;
            rd_word[RES_REFUSED_BIT]    = res_r.refused;
            rd_word[RES_LINK_BIT]       = res_link_r;
            rd_word[RES_BUSY_BIT]       = go_r;
            rd_word[RES_FREE_LSB +: 8]  = {2'h0, seg_max(ctrl_r[CTRL_EXT_BIT])} -
                                          seg_total(cnts_r);
         end
         OFS_COUNT:
            for (int i = 0; i < 4; i++)
            begin
               rd_word[i * 8 +: 6] = cnts_r[i];
            end
         OFS_RUN:
            rd_word[RUN_EXEC_BIT] = exec_r;
         OFS_SEGTIME:
            rd_word[15:0] = segtime_r;
         OFS_STATUS:
         begin
            rd_word[ST_FLAG_BIT]         = flag;
            rd_word[ST_WAIT_BIT]         = own_wait;
            rd_word[ST_BLANK_BIT]        = blank;
            rd_word[ST_EXEC_BIT]         = running;
            rd_word[ST_SEG_LSB +: 6]     = seg_r;
            rd_word[ST_REMAIN_LSB +: 16] = remain_r;
         end
         default:
            rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (psel & penable & ~pready_r & ~pwrite)
         prdata_r <= rd_word;
   end

   // software-written control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r    <= CTRL_RST;
         exec_r    <= 1'b0;
         segtime_r <= SEGTIME_RST;
      end
      else if (wr_done)
      begin
         if (paddr == OFS_CTRL)
            ctrl_r <= pwdata[5:0];
         if (paddr == OFS_RUN)
            exec_r <= pwdata[RUN_EXEC_BIT];
         if (paddr == OFS_SEGTIME)
            segtime_r <= pwdata[15:0];
      end
   end

   // command capture, launched one cycle later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_r <= '{op: OP_NONE, link: 1'b0, pa: 3'h0, pb: 3'h0, seg: 6'h00};
         go_r  <= 1'b0;
      end
      else
      begin
         go_r <= wr_done && (paddr == OFS_CMD);
         if (wr_done && (paddr == OFS_CMD))
         begin
            req_r.op   <= pes_op_e'(pwdata[CMD_OP_LSB +: 3]);
            req_r.link <= pwdata[CMD_LINK_BIT];
            req_r.pa   <= pwdata[CMD_PA_LSB +: 3];
            req_r.pb   <= pwdata[CMD_PB_LSB +: 3];
            req_r.seg  <= pwdata[CMD_SEG_LSB +: 6];
         end
      end
   end

   pes_edit_check u_check (
      .req     (req_r),
      .running (running),
      .ext_opt (ctrl_r[CTRL_EXT_BIT]),
      .cnts    (cnts_r),
      .res     (verdict)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_r      <= '{refused: 1'b0, comm: RC_OK, panel: PE_NONE};
         res_link_r <= 1'b0;
      end
      else if (go_r && req_r.op != OP_NONE)
      begin
         res_r      <= verdict;
         res_link_r <= req_r.link;
      end
   end

   // segment counts per pattern
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnts_r <= '0;
      else if (go_r && !verdict.refused)
      begin
         unique case (req_r.op)
            OP_CLR_PAT:
               cnts_r[pat_idx(req_r.pa)] <= 6'h00;
            OP_CLR_ALL:
               cnts_r <= '0;
            OP_COPY:
               cnts_r[pat_idx(req_r.pa)] <= cnts_r[pat_idx(req_r.pb)];
            OP_INS_SEG:
               cnts_r[pat_idx(req_r.pa)] <= cnts_r[pat_idx(req_r.pa)] + 6'h01;
            OP_DEL_SEG:
               cnts_r[pat_idx(req_r.pa)] <= cnts_r[pat_idx(req_r.pa)] - 6'h01;
            OP_WR_SEG:
               if (req_r.seg == cnts_r[pat_idx(req_r.pa)] + 6'h01)
                  cnts_r[pat_idx(req_r.pa)] <= req_r.seg;
            default:
               cnts_r <= cnts_r;
         endcase
      end
   end

   // second ticks for remaining time
   assign sec_tick = (sec_cnt_r == 26'(SEC_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sec_cnt_r <= 26'h0000000;
      else if (state_r != ST_TIMING || sec_tick)
         sec_cnt_r <= 26'h0000000;
      else
         sec_cnt_r <= sec_cnt_r + 26'h0000001;
   end

   assign own_wait = (state_r == ST_BOUNDARY) && (jc == JC_WAIT_AT_BOUNDARY) && out_of_zone_in;
   // wait contact gated by selection and switch
   assign wait_eff = wait_in & ctrl_r[CTRL_WSEL_BIT] & ctrl_r[CTRL_WSW_BIT];
   // advance only when every flag is off
   assign advance  = (state_r == ST_BOUNDARY) && (jc != JC_HOLD) && !own_wait && !wait_eff;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
            if (exec_r)
               state_nxt = ST_TIMING;
         ST_TIMING:
            if (!exec_r)
               state_nxt = ST_IDLE;
            else if (remain_r == 16'h0000)
               state_nxt = ST_BOUNDARY;
         ST_BOUNDARY:
            if (!exec_r)
               state_nxt = ST_IDLE;
            else if (jc == JC_HOLD)
               state_nxt = ST_HELD;
            else if (advance)
               state_nxt = ST_TIMING;
         ST_HELD:
            if (!exec_r)
               state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // remaining time and segment index
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         remain_r <= 16'h0000;
         seg_r    <= 6'h00;
      end
      else if (state_r == ST_IDLE)
      begin
         remain_r <= segtime_r;
         seg_r    <= exec_r ? 6'h01 : 6'h00;
      end
      else if (advance && exec_r)
      begin
         remain_r <= segtime_r;
         seg_r    <= seg_r + 6'h01;
      end
      else if (state_r == ST_TIMING && sec_tick && remain_r != 16'h0000)
         remain_r <= remain_r - 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seg_adv_r <= 1'b0;
      else
         seg_adv_r <= advance & exec_r;
   end

   pes_sync_flag #(
      .BLANK_CYCLES (BLANK_CYCLES)
   ) u_sync (
      .clk       (pclk),
      .rst_n     (presetn),
      .executing (running),
      .wait_sw   (ctrl_r[CTRL_WSW_BIT]),
      .al3_sel   (ctrl_r[CTRL_AL3_BIT]),
      .own_wait  (own_wait),
      .remain_nz (remain_r != 16'h0000),
      .seg_adv   (seg_adv_r),
      .flag_r    (flag),
      .blank_r   (blank)
   );

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign alarm3_out      = flag;
   assign seg_advance_out = seg_adv_r;

endmodule : pes_top

/* verification/pes_peer.sv */
// peer controller sharing the wait contact
`timescale 1ns/1ps
module pes_peer
(
   // clock and reset
   input  logic clk,
   input  logic rst_n,
   // contacts
   input  logic own_flag,
   input  logic stall,
   output logic wait_line
);
   logic busy_r;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         busy_r <= 1'b0;
      else
         busy_r <= stall;
   assign wait_line = own_flag | busy_r;
endmodule : pes_peer

/* verification/pes_chk.sv */
// port assertions of the pattern editor and sync block
`timescale 1ns/1ps
module pes_chk
   import pes_pkg::*;
#(
   parameter int unsigned SEC_CYCLES   = 20,
   parameter int unsigned BLANK_CYCLES = 10
)
(
   // clock and reset
   input logic        pclk,
   input logic        presetn,
   // apb
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   // contacts
   input logic        wait_in,
   input logic        alarm3_out,
   input logic        seg_advance_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY_LAT: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("pready too long");
   AST_ERR_RDY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_ERR_RD0: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("read data moved");
   AST_ADV_PULSE: assert property (seg_advance_out |=> !seg_advance_out)
      else $error("advance pulse too long");
   AST_ADV_WAIT: assert property (seg_advance_out |-> !$past(wait_in))
      else $error("advance while waiting");
   AST_BLANK: assert property (seg_advance_out |-> ##2 !alarm3_out [*8])
      else $error("flag not blanked");
endmodule : pes_chk

bind pes_top pes_chk #(.SEC_CYCLES(SEC_CYCLES), .BLANK_CYCLES(BLANK_CYCLES)) i_pes_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .wait_in, .alarm3_out, .seg_advance_out);

/* verification/tb.sv */
// self-checking bench of the pattern editor and sync block
`timescale 1ns/1ps
module tb
   import pes_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e_r, wait_in, oz = 0, stall = 0;
   logic        alarm3_out, seg_advance_out;
   int          err_count = 0, num_checks = 0, cnt[4], run = 0, ext = 0, k, op, pa, sg;
   int          ed[16][4] = '{'{1,2,0,0}, '{6,2,0,1}, '{4,1,0,1}, '{3,2,1,0},
      '{3,1,2,0}, '{7,0,0,0}, '{3,2,1,0}, '{3,2,1,0}, '{1,5,0,0}, '{1,0,0,0},
      '{6,2,0,41}, '{6,2,0,0}, '{5,2,0,1}, '{4,2,0,1}, '{1,2,0,0}, '{2,1,0,0}};
   initial forever #12.5 pclk = ~pclk;
   pes_top #(.SEC_CYCLES(20), .BLANK_CYCLES(10)) i_pes_top (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_in,
      .out_of_zone_in(oz), .alarm3_out, .seg_advance_out);
   pes_peer i_pes_peer (.clk(pclk), .rst_n(presetn), .own_flag(alarm3_out), .stall,
      .wait_line(wait_in));
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task automatic tmo;
      err_count++;
      $display("mismatch at %0t: wait timed out", $time);
      test_done();
   endtask : tmo
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 20) tmo();
      q = prdata;
      e_r = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic ctl(input logic [5:0] v);
      apb(1, OFS_CTRL, {26'h0, v});
      ext = v[0];
   endtask : ctl
   task automatic wt(input int sel, input logic v);
      int n;
      for (n = 0; n < 400 && (sel ? seg_advance_out : alarm3_out) !== v; n++) @(posedge pclk);
      if (n == 400) tmo();
   endtask : wt
   task automatic hi(input int sel, output int h);
      h = 0;
      repeat (2) @(posedge pclk);
      repeat (60)
      begin
         @(posedge pclk);
         h += (sel ? seg_advance_out : alarm3_out) === 1'b1;
      end
   endtask : hi
   task automatic cmd(input int op, input int pa, input int pb, input int sg);
      int c, p, pm, sm, t;
      pm = ext ? 4 : 2;
      sm = ext ? 40 : 20;
      t = cnt[0] + cnt[1] + cnt[2] + cnt[3];
      c = 0;
      p = -1;
      apb(1, OFS_CMD, {10'h0, sg[5:0], 1'b0, pb[2:0], 1'b0, pa[2:0], 5'h01, op[2:0]});
      if (run) c = 1;
      else if (pa < 1 || pa > pm || (op == 3 && (pb < 1 || pb > pm))) c = 2;
      else if (op >= 4 && (sg < 1 || sg > sm)) c = 3;
      else case (op)
         1: if (cnt[pa-1] == 0) c = 41; else cnt[pa-1] = 0;
         2: cnt = '{0, 0, 0, 0};
         3: if (cnt[pb-1] == 0) {c, p} = {32'd31, 32'd32};
            else if (cnt[pa-1] != 0) {c, p} = {32'd31, 32'd33};
            else if (t + cnt[pb-1] > sm) c = 22;
            else cnt[pa-1] = cnt[pb-1];
         4: if (cnt[pa-1] >= sm) {c, p} = {32'd22, 32'd23};
            else if (t >= sm) c = 22;
            else if (sg > cnt[pa-1]) c = 3;
            else cnt[pa-1]++;
         5: if (sg > cnt[pa-1]) c = 3; else cnt[pa-1]--;
         6: if (sg > cnt[pa-1] + 1) c = 3;
            else if (sg > cnt[pa-1] && t >= sm) c = 22;
            else if (sg > cnt[pa-1]) cnt[pa-1]++;
      endcase
      if (p < 0) p = (c == 2 || c == 3) ? 0 : c;
      apb(0, OFS_RESULT, 0);
      chk(q[7:0], c);
      chk(q[15:8], p);
      chk(q[16], c != 0);
      chk(q[17], 1'b1);
      chk(q[31:24], sm - (cnt[0] + cnt[1] + cnt[2] + cnt[3]));
   endtask : cmd
   initial
   begin
      repeat (100000) @(posedge pclk);
      tmo();
   end
   initial
   begin
      k = $urandom(74711);
      cnt = '{0, 0, 0, 0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_CTRL, 0);
      chk(q, {26'h0, CTRL_RST});
      apb(0, OFS_SEGTIME, 0);
      chk(q, {16'h0, SEGTIME_RST});
      apb(0, 8'hFC, 0);
      chk(q, 0);
      chk(e_r, 1);
      $display("reset test done");
      for (k = 1; k <= 21; k++) cmd(6, 1, 0, k);
      foreach (ed[i])
         if (ed[i][0] == 7) ctl(CTRL_RST | 6'h01);
         else cmd(ed[i][0], ed[i][1], ed[i][2], ed[i][3]);
      repeat (40)
      begin
         op = $urandom_range(1, 6);
         pa = op == 2 ? 1 : $urandom_range(0, 5);
         sg = (pa >= 1 && pa <= 4) ? $urandom_range(1, cnt[pa-1] + 1) : 1;
         cmd(op, pa, $urandom_range(0, 5), sg);
      end
      $display("edit test done");
      cmd(2, 1, 0, 0);
      ctl(CTRL_RST);
      stall <= 1'b1;
      apb(1, OFS_RUN, 1);
      run = 1;
      wt(0, 1);
      chk(alarm3_out, 1);
      for (k = 1; k <= 5; k++) cmd(k, 1, 2, 1);
      wt(0, 0);
      hi(1, k);
      chk(k, 0);
      ctl(CTRL_RST | 6'h10);
      oz <= 1'b1;
      wt(0, 1);
      chk(alarm3_out, 1);
      oz <= 1'b0;
      wt(0, 0);
      stall <= 1'b0;
      wt(1, 1);
      chk(seg_advance_out, 1);
      wt(0, 1);
      ctl(CTRL_RST & 6'h3D);
      hi(0, k);
      chk(k, 0);
      ctl(CTRL_RST & 6'h37);
      hi(0, k);
      chk(k, 0);
      ctl(CTRL_RST);
      apb(1, OFS_RUN, 0);
      run = 0;
      hi(0, k);
      chk(k, 0);
      cmd(2, 1, 0, 0);
      $display("sync test done");
      test_done();
   end
endmodule : tb
